// [verilog/fpbm_map.svh]
`ifndef FPBM_MAP_SVH
`define FPBM_MAP_SVH
`define FPBM_PAGES_PER_BANK      1024
`define FPBM_PAGE_BYTES          256
`define FPBM_WBUF_BYTES          128
`define FPBM_LOCK_BITS           32
`define FPBM_LOCK_PAGES          64
`define FPBM_GPNV_BITS           3
`define FPBM_GPNV_SECURITY       0
`define FPBM_GPNV_BOOT_FLASH     1
`define FPBM_GPNV_BOOT_BANK      2
`define FPBM_ROM_BASE            32'h0018_0000
`define FPBM_FLASH0_BASE         32'h0008_0000
`define FPBM_WIPE_MS             200
`define FPBM_CLK_MHZ             200
`define FPBM_WIPE_CYCLES         (`FPBM_WIPE_MS * 1000 * `FPBM_CLK_MHZ)
`define FPBM_ERASE_CYCLES        64
`define FPBM_OP_CYCLES           8
`define FPBM_DESC_WORDS          4
`define FPBM_RST_RR              8'h00
`endif

// [verilog/fpbm_pkg.sv]
package fpbm_pkg;
    typedef enum logic [3:0] {
        FPBM_CMD_NONE, FPBM_CMD_READ, FPBM_CMD_PAGE_PROG, FPBM_CMD_PAGE_ERASE,
        FPBM_CMD_FULL_ERASE, FPBM_CMD_LOCK, FPBM_CMD_UNLOCK, FPBM_CMD_SET_GPNV,
        FPBM_CMD_CLR_GPNV, FPBM_CMD_GET_DESC, FPBM_CMD_WBUF_WRITE
    } fpbm_cmd_e;

    typedef struct packed {
        logic        valid;
        fpbm_cmd_e   cmd;
        logic [15:0] arg;
        logic [31:0] data;
    } fpbm_req_s;

    typedef struct packed {
        logic        done;
        logic        locked_err;
        logic        refused;
        logic [31:0] data;
    } fpbm_rsp_s;

    typedef struct packed {
        logic        boot_from_flash;
        logic        boot_bank1;
        logic [31:0] boot_base;
        logic [31:0] rom_base;
    } fpbm_map_s;
endpackage : fpbm_pkg

// [verilog/fpbm_top.sv]
// Functional notes
// (R1) Two banks, 1024 or 512 pages
// (R2) 128-byte write buffer via 32-bit words
// (R3) Software picks 128-bit or 64-bit read
// (R4) Descriptor command reports flash organisation
// (R5) Lock regions of 64 pages each
// (R6) Locked erase/program aborts and raises interrupt; full erase is not checked against lock bits
// (R7) Set-lock protects, clear-lock unprotects region
// (R8) Wipe pin clears all lock bits
// (R9) Security bit blocks debug and parallel access
// (R10) Security set by command, cleared by wipe
// (R11) Wipe held over 200 ms
// (R12) Unique identifier is fixed, wipe-immune
// (R13) Calibration bits fixed, wipe-immune
// (R14) Programmer entry via pins and reset edge
// (R15) Handshaked parallel programming port
// (R16) Port accepts read, program, erase, lock, protect
// (R17) ROM always at its fixed address
// (R18) Address zero maps flash or ROM
// (R19) Wipe clears boot-from-flash bit
// (R20) Bit 2 selects boot bank
// (R21) Three nonvolatile bits, set/clear commands
// (R22) Nonvolatile bits survive reset, sampled at reset
`timescale 1ns/1ps
`default_nettype none
`include "fpbm_map.svh"

module fpbm_top #(
    parameter int          PAGES_PER_BANK = `FPBM_PAGES_PER_BANK,
    parameter int          LOCK_BITS      = `FPBM_LOCK_BITS,
    parameter int unsigned WIPE_CYCLES    = `FPBM_WIPE_CYCLES,
    parameter logic [127:0] UNIQUE_ID     = 128'h0123_4567_89AB_CDEF_0011_2233_4455_6677,
    parameter logic [15:0]  CALIB_BITS    = 16'hA5C3
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire fpbm_pkg::fpbm_req_s sw_req,
    input  wire logic              wide_read_sel,
    input  wire logic              debug_access_req,
    input  wire logic              wipe_pin,
    input  wire logic              factory_test_pin,
    input  wire logic              external_reset_n,
    input  wire logic              prog_cmd_strobe_n,
    input  wire logic              prog_output_enable_n,
    input  wire logic [3:0]        prog_mode_sel,
    input  wire logic [15:0]       prog_data_in,
    output var fpbm_pkg::fpbm_rsp_s  sw_rsp,
    output var fpbm_pkg::fpbm_map_s  boot_map,
    output logic                   flash_irq,
    output logic                   read_width_128,
    output logic                   debug_grant,
    output logic                   prog_mode_active,
    output logic                   prog_ready_line,
    output logic                   prog_data_valid_n,
    output logic [15:0]            prog_data_out,
    output logic                   prog_data_oe,
    output logic                   array_write_en,
    output logic [15:0]            array_page,
    output logic [31:0]            wbuf_word_out,
    output logic [127:0]           unique_id_out,
    output logic [15:0]            calib_out
);
    import fpbm_pkg::*;

    localparam int PAGE_W = $clog2(2 * PAGES_PER_BANK);
    localparam int WB_WORDS = `FPBM_WBUF_BYTES / 4;

    // ****************************************
    // Pin synchronisers (3 stages, 2-3 agree; mode select has no agree check)
    // ****************************************
    logic [5:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
    wire  [5:0] pin_raw = {wipe_pin, factory_test_pin, external_reset_n,
                           prog_cmd_strobe_n, prog_output_enable_n, debug_access_req};
    always_ff @(posedge ref_clk) begin
        pin_s1_r <= pin_raw;
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r;
        for (int i = 0; i < 6; i++) begin
            if (pin_s2_r[i] == pin_s3_r[i]) pin_r[i] <= pin_s3_r[i];
        end
    end
    wire wipe_q  = pin_r[5];
    wire tst_q   = pin_r[4];
    wire external_reset_n_q  = pin_r[3];
    wire ncmd_q  = pin_r[2];
    wire noe_q   = pin_r[1];
    wire dbg_q   = pin_r[0];
    logic [15:0] pdata_s1_r, pdata_s2_r, pdata_s3_r, pdata_r;
    logic [3:0]  pmode_s1_r, pmode_s2_r, pmode_r;
    always_ff @(posedge ref_clk) begin
        pdata_s1_r <= prog_data_in;
        pdata_s2_r <= pdata_s1_r;
        pdata_s3_r <= pdata_s2_r;
        if (pdata_s2_r == pdata_s3_r) pdata_r <= pdata_s3_r;
        pmode_s1_r <= prog_mode_sel;
        pmode_s2_r <= pmode_s1_r;
        pmode_r    <= pmode_s2_r;
    end

    // ****************************************
    // Nonvolatile state
    // ****************************************
    // Not reset by sys_rst: models cells that survive resets and power cycles
    logic [LOCK_BITS-1:0] lock_r = '0;        // (R5)
    logic [2:0]           gpnv_r = '0;        // (R21)
    logic [31:0]          wbuf_r [WB_WORDS];  // (R2)

    function automatic logic [4:0] region_of(input logic [15:0] page);
        region_of = 5'(page / `FPBM_LOCK_PAGES);   // (R5)
    endfunction

    // ****************************************
    // Wipe pin timing
    // ****************************************
    logic [31:0] wipe_cnt_r;
    logic        wipe_done_r;
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !wipe_q) begin
            wipe_cnt_r  <= '0;
            wipe_done_r <= 1'b0;
        end else if (wipe_cnt_r < WIPE_CYCLES) begin
            wipe_cnt_r <= wipe_cnt_r + 32'h1;
        end else begin
            wipe_done_r <= 1'b1;   // (R11) wipe fires once, after the hold
        end
    end
    wire wipe_fire = wipe_q && (wipe_cnt_r == WIPE_CYCLES) && !wipe_done_r;

    // ****************************************
    // Programming port entry
    // ****************************************
    logic external_reset_n_d_r;
    // Output enable is held low by the programmer; the valid line is ours and idles high
    wire  entry_ok = tst_q && ncmd_q && prog_ready_line && !noe_q
                     && prog_data_valid_n;   // (R14)
    always_ff @(posedge ref_clk) begin
        external_reset_n_d_r <= external_reset_n_q;
        if (sys_rst) prog_mode_active <= 1'b0;
        else if (!tst_q) prog_mode_active <= 1'b0;
        else if (!external_reset_n_d_r && external_reset_n_q && entry_ok)
            prog_mode_active <= 1'b1;   // (R14)
    end

    // ****************************************
    // Command arbitration
    // ****************************************
    wire secure   = gpnv_r[`FPBM_GPNV_SECURITY];
    logic ncmd_d_r;
    always_ff @(posedge ref_clk) ncmd_d_r <= ncmd_q;
    wire  port_cmd = prog_mode_active && ncmd_d_r && !ncmd_q;   // (R15)
    wire  port_ok  = port_cmd && !secure;                       // (R9)
    fpbm_cmd_e cmd;
    logic [15:0] arg;
    assign cmd = port_ok ? fpbm_cmd_e'(pmode_r) : (sw_req.valid ? sw_req.cmd : FPBM_CMD_NONE);
    assign arg = port_ok ? pdata_r : sw_req.arg;
    wire  [4:0] reg_sel  = region_of(arg);
    wire        tgt_lock = lock_r[reg_sel];
    wire        is_mod   = (cmd == FPBM_CMD_PAGE_PROG) || (cmd == FPBM_CMD_PAGE_ERASE);
    wire        abort    = is_mod && tgt_lock;                  // (R6)
    wire        port_sec = port_cmd && secure;                  // (R9)

    // ****************************************
    // Command execution
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sw_rsp            <= '0;
            flash_irq         <= 1'b0;
            array_write_en    <= 1'b0;
            array_page        <= '0;
            wbuf_word_out     <= '0;
            prog_ready_line   <= 1'b1;
            prog_data_valid_n <= 1'b1;
            prog_data_out     <= '0;
            prog_data_oe      <= 1'b0;
        end else begin
            sw_rsp         <= '0;
            flash_irq      <= 1'b0;
            array_write_en <= 1'b0;
            prog_data_valid_n <= 1'b1;
            prog_data_oe   <= prog_mode_active && !noe_q;
            if (port_sec) begin
                sw_rsp.refused <= 1'b1;
            end
            if (cmd != FPBM_CMD_NONE) begin
                sw_rsp.done <= 1'b1;
                if (abort) begin
                    sw_rsp.locked_err <= 1'b1;
                    flash_irq         <= 1'b1;   // (R6)
                end else begin
                    case (cmd)
                        FPBM_CMD_WBUF_WRITE: wbuf_r[arg[4:0]] <= sw_req.data;  // (R2)
                        FPBM_CMD_PAGE_PROG, FPBM_CMD_PAGE_ERASE: begin
                            array_write_en <= 1'b1;
                            array_page     <= arg;
                            wbuf_word_out  <= wbuf_r[0];
                        end
                        FPBM_CMD_FULL_ERASE: array_write_en <= 1'b1;
                        FPBM_CMD_LOCK:   lock_r[reg_sel] <= 1'b1;   // (R7)
                        FPBM_CMD_UNLOCK: lock_r[reg_sel] <= 1'b0;   // (R7)
                        FPBM_CMD_SET_GPNV: if (arg < 16'h0003) gpnv_r[arg[1:0]] <= 1'b1; // (R21)
                        FPBM_CMD_CLR_GPNV: // Security bit cannot be cleared by command (R10)
                            if (arg < 16'h0003 && arg != 16'h0000) gpnv_r[arg[1:0]] <= 1'b0;
                        FPBM_CMD_GET_DESC: // (R4) (R1)
                            sw_rsp.data <= {16'(PAGES_PER_BANK), 8'h02, 8'(LOCK_BITS)};
                        FPBM_CMD_READ: sw_rsp.data <= {16'h0000, arg};
                        default: ;
                    endcase
                    if (port_ok) begin   // (R16)
                        prog_data_out     <= (cmd == FPBM_CMD_GET_DESC) ?
                                             16'(PAGES_PER_BANK) : arg;
                        prog_data_valid_n <= 1'b0;
                    end
                end
            end
            prog_ready_line <= !port_cmd;
            if (wipe_fire) begin
                lock_r <= '0;                                   // (R8)
                gpnv_r[`FPBM_GPNV_SECURITY]   <= 1'b0;          // (R10)
                gpnv_r[`FPBM_GPNV_BOOT_FLASH] <= 1'b0;          // (R19)
            end
        end
    end

    // ****************************************
    // Boot fields sampled at reset; ROM base and other outputs registered every cycle
    // ****************************************
    always_ff @(posedge ref_clk) begin
        read_width_128 <= wide_read_sel;                        // (R3)
        debug_grant    <= dbg_q && !secure;                     // (R9)
        unique_id_out  <= UNIQUE_ID;                            // (R12)
        calib_out      <= CALIB_BITS;                           // (R13)
        if (sys_rst) begin   // (R22)
            boot_map.boot_from_flash <= gpnv_r[`FPBM_GPNV_BOOT_FLASH];
            boot_map.boot_bank1      <= gpnv_r[`FPBM_GPNV_BOOT_BANK];   // (R20)
            boot_map.boot_base <= !gpnv_r[`FPBM_GPNV_BOOT_FLASH] ? `FPBM_ROM_BASE :
                                  (`FPBM_FLASH0_BASE +
                                   (gpnv_r[`FPBM_GPNV_BOOT_BANK] ?
                                    32'(PAGES_PER_BANK * `FPBM_PAGE_BYTES) : 32'h0)); // (R18)
        end
        boot_map.rom_base <= `FPBM_ROM_BASE;                    // (R17)
    end
endmodule : fpbm_top
`default_nettype wire

// [dv/fpbm_top_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fpbm_map.svh"
module fpbm_top_chk
    import fpbm_pkg::*;
(
    input wire logic                ref_clk,
    input wire logic                sys_rst,
    input wire fpbm_pkg::fpbm_req_s sw_req,
    input wire logic                wide_read_sel,
    input wire fpbm_pkg::fpbm_rsp_s sw_rsp,
    input wire fpbm_pkg::fpbm_map_s boot_map,
    input wire logic                flash_irq,
    input wire logic                read_width_128,
    input wire logic                prog_mode_active,
    input wire logic                prog_data_valid_n,
    input wire logic                prog_data_oe,
    input wire logic                array_write_en,
    input wire logic [127:0]        unique_id_out,
    input wire logic [15:0]         calib_out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ****************************************
    // Properties
    // ****************************************
    property p_done;
        sw_req.valid && sw_req.cmd != FPBM_CMD_NONE && !prog_mode_active |=> sw_rsp.done;
    endproperty
    property p_irq; 1'b1 |-> flash_irq == sw_rsp.locked_err; endproperty
    property p_nowr; sw_rsp.locked_err |-> !array_write_en ##1 !array_write_en; endproperty
    // The boot map is loaded during reset, so skip the first edge after release
    property p_rom; !$past(sys_rst) |-> boot_map.rom_base == `FPBM_ROM_BASE; endproperty
    property p_rom_boot;
        !$past(sys_rst) && !boot_map.boot_from_flash |-> boot_map.boot_base == `FPBM_ROM_BASE;
    endproperty
    property p_bank0;
        !$past(sys_rst) && boot_map.boot_from_flash && !boot_map.boot_bank1
            |-> boot_map.boot_base == `FPBM_FLASH0_BASE;
    endproperty
    property p_hold; !$past(sys_rst) |-> $stable(boot_map); endproperty
    property p_fixed;
        !$past(sys_rst) && !$past(sys_rst, 2)
            |-> $stable(unique_id_out) && $stable(calib_out) && unique_id_out != '0;
    endproperty
    property p_width; $stable(wide_read_sel) [*4] |-> read_width_128 == wide_read_sel; endproperty
    property p_valid; !prog_data_valid_n |-> prog_mode_active ##1 prog_data_valid_n; endproperty
    property p_oe; prog_data_oe |-> prog_mode_active; endproperty
    a_done: assert property (p_done) else $error("command not answered");
    a_irq: assert property (p_irq) else $error("irq and abort differ");
    a_nowr: assert property (p_nowr) else $error("aborted command wrote array");
    a_rom: assert property (p_rom) else $error("rom base moved");
    a_rom_boot: assert property (p_rom_boot) else $error("rom boot base wrong");
    a_bank0: assert property (p_bank0) else $error("bank 0 boot base wrong");
    a_hold: assert property (p_hold) else $error("boot map changed out of reset");
    a_fixed: assert property (p_fixed) else $error("factory constants changed");
    a_width: assert property (p_width) else $error("read width wrong");
    a_valid: assert property (p_valid) else $error("data valid pulse wrong");
    a_oe: assert property (p_oe) else $error("data driven outside mode");
    c_err: cover property (sw_rsp.locked_err);
    c_refused: cover property (sw_rsp.refused);
    c_valid: cover property (!prog_data_valid_n);
endmodule : fpbm_top_chk
bind fpbm_top fpbm_top_chk u_chk (.ref_clk, .sys_rst, .sw_req, .wide_read_sel, .sw_rsp,
    .boot_map, .flash_irq, .read_width_128, .prog_mode_active, .prog_data_valid_n,
    .prog_data_oe, .array_write_en, .unique_id_out, .calib_out);
`default_nettype wire

// [dv/fpbm_prog_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fpbm_prog_model (
    input  wire logic        ref_clk,
    input  wire logic        prog_ready_line,
    input  wire logic        prog_data_valid_n,
    input  wire logic [15:0] prog_data_out,
    output logic             factory_test_pin,
    output logic             external_reset_n,
    output logic             prog_cmd_strobe_n,
    output logic             prog_output_enable_n,
    output logic [3:0]       prog_mode_sel,
    output logic [15:0]      prog_data_in
);
    int unsigned valid_cnt = 0;
    initial begin
        factory_test_pin = 1'b0;
        external_reset_n = 1'b1;
        prog_cmd_strobe_n = 1'b1;
        prog_output_enable_n = 1'b1;
        prog_mode_sel = 4'h0;
        prog_data_in = 16'hFFFF;
    end
    always @(posedge ref_clk) begin
        if (prog_data_valid_n === 1'b0) valid_cnt++;
    end
    task automatic enter();
        @(posedge ref_clk);
        #1 factory_test_pin = 1'b1;
        prog_cmd_strobe_n = 1'b1;
        prog_output_enable_n = 1'b0;
        external_reset_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 external_reset_n = 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask : enter
    task automatic cmd(input logic [3:0] code, input logic [15:0] arg);
        int n;
        n = 0;
        @(posedge ref_clk);
        #1 prog_mode_sel = code;
        prog_data_in = arg;
        prog_cmd_strobe_n = 1'b0;
        do @(posedge ref_clk); while (prog_ready_line !== 1'b0 && ++n < 20);
        #1 prog_cmd_strobe_n = 1'b1;
        // Released data lines never keep their last value; mode select keeps its code
        prog_data_in = ~arg;
        repeat (6) @(posedge ref_clk);
    endtask : cmd
endmodule : fpbm_prog_model
`default_nettype wire

// [dv/test_flash_protect_boot_map.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fpbm_map.svh"
module test_flash_protect_boot_map;
    import fpbm_pkg::*;
    typedef struct {fpbm_cmd_e c; logic [15:0] a; logic [31:0] d; logic e;} fpbm_row_s;
    logic ref_clk = 1'b0, sys_rst, wide_read_sel, debug_access_req, wipe_pin;
    fpbm_req_s sw_req;
    fpbm_rsp_s sw_rsp;
    fpbm_map_s boot_map;
    logic flash_irq, read_width_128, debug_grant, prog_mode_active, prog_ready_line;
    logic prog_data_valid_n, prog_data_oe, array_write_en, factory_test_pin, external_reset_n;
    logic prog_cmd_strobe_n, prog_output_enable_n;
    logic [3:0] prog_mode_sel;
    logic [15:0] prog_data_in, prog_data_out, array_page, calib_out;
    logic [31:0] wbuf_word_out;
    logic [127:0] unique_id_out;
    int mismatches = 0, num_checks = 0, cycles = 0, n, r, refused_cnt = 0;
    fpbm_row_s rows[] = '{'{FPBM_CMD_WBUF_WRITE, 16'h0000, 32'hA5A5_5A5A, 0},
        '{FPBM_CMD_LOCK, 16'h0040, 0, 0}, '{FPBM_CMD_PAGE_PROG, 16'h0046, 0, 1},
        '{FPBM_CMD_PAGE_ERASE, 16'h007F, 0, 1}, '{FPBM_CMD_PAGE_PROG, 16'h0080, 0, 0},
        '{FPBM_CMD_PAGE_ERASE, 16'h003F, 0, 0}, '{FPBM_CMD_UNLOCK, 16'h0040, 0, 0},
        '{FPBM_CMD_PAGE_PROG, 16'h0046, 0, 0}, '{FPBM_CMD_LOCK, 16'h07FF, 0, 0},
        '{FPBM_CMD_PAGE_PROG, 16'h07C0, 0, 1},
        '{FPBM_CMD_SET_GPNV, 16'h0001, 0, 0}, '{FPBM_CMD_SET_GPNV, 16'h0002, 0, 0},
        '{FPBM_CMD_GET_DESC, 16'h0000, 0, 0}, '{FPBM_CMD_READ, 16'h0000, 0, 0}};
    always #2.5 ref_clk = ~ref_clk;
    fpbm_top #(.WIPE_CYCLES(50)) dut (.ref_clk, .sys_rst, .sw_req, .wide_read_sel,
        .debug_access_req, .wipe_pin, .factory_test_pin, .external_reset_n, .prog_cmd_strobe_n,
        .prog_output_enable_n, .prog_mode_sel, .prog_data_in, .sw_rsp, .boot_map, .flash_irq,
        .read_width_128, .debug_grant, .prog_mode_active, .prog_ready_line, .prog_data_valid_n,
        .prog_data_out, .prog_data_oe, .array_write_en, .array_page, .wbuf_word_out,
        .unique_id_out, .calib_out);
    fpbm_prog_model prog (.ref_clk, .prog_ready_line, .prog_data_valid_n, .prog_data_out,
        .factory_test_pin, .external_reset_n, .prog_cmd_strobe_n, .prog_output_enable_n,
        .prog_mode_sel, .prog_data_in);
    // ****************************************
    // Tasks
    // ****************************************
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task automatic chk1(string nm, logic e, logic s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", nm, e, s);
        end
    endtask : chk1
    task automatic chk32(string nm, logic [31:0] e, logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk32
    // Returns just after the taking edge, where the one-cycle answer stands
    task automatic req(fpbm_cmd_e c, logic [15:0] a, logic [31:0] d);
        @(posedge ref_clk);
        #1 sw_req = {1'b1, c, a, d};
        @(posedge ref_clk);
        #1 sw_req.valid = 1'b0;
    endtask : req
    task automatic do_rst();
        @(posedge ref_clk);
        #1 sys_rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
    endtask : do_rst
    always @(posedge ref_clk) begin
        if (sw_rsp.refused === 1'b1) refused_cnt++;
        if (++cycles > 3000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        sys_rst = 1'b1;
        sw_req = '0;
        wide_read_sel = 1'b0;
        debug_access_req = 1'b1;
        wipe_pin = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        wide_read_sel = 1'b1;
        chk1("ready_idle", 1'b1, prog_ready_line);
        foreach (rows[i]) begin
            req(rows[i].c, rows[i].a, rows[i].d);
            chk1("done", 1'b1, sw_rsp.done);
            chk1("locked_err", rows[i].e, sw_rsp.locked_err);
            chk1("irq", rows[i].e, flash_irq);
            if (rows[i].c == FPBM_CMD_GET_DESC) chk32("desc", 32'h0400_0220, sw_rsp.data);
        end
        chk32("wbuf", 32'hA5A5_5A5A, wbuf_word_out);
        chk32("page", 32'h0000_0046, {16'h0000, array_page});
        chk1("width", 1'b1, read_width_128);
        chk1("debug_open", 1'b1, debug_grant);
        prog.enter();
        chk1("mode", 1'b1, prog_mode_active);
        prog.cmd(4'(FPBM_CMD_LOCK), 16'h0000);
        req(FPBM_CMD_PAGE_PROG, 16'h0005, 0);
        chk1("port_lock", 1'b1, sw_rsp.locked_err);
        n = prog.valid_cnt;
        prog.cmd(4'(FPBM_CMD_READ), 16'h0123);
        chk1("port_read", 1'b1, prog.valid_cnt == n + 1);
        chk32("port_data", 32'h0000_0123, {16'h0000, prog_data_out});
        do_rst();
        chk1("boot_flash", 1'b1, boot_map.boot_from_flash);
        chk1("boot_bank1", 1'b1, boot_map.boot_bank1);
        req(FPBM_CMD_SET_GPNV, 16'h0000, 0);
        req(FPBM_CMD_CLR_GPNV, 16'h0000, 0);
        repeat (8) @(posedge ref_clk);
        chk1("debug_secure", 1'b0, debug_grant);
        prog.enter();
        n = prog.valid_cnt;
        r = refused_cnt;
        prog.cmd(4'(FPBM_CMD_READ), 16'h0000);
        chk1("secure_read", 1'b1, prog.valid_cnt == n);
        chk1("refused", 1'b1, refused_cnt > r);
        req(FPBM_CMD_LOCK, 16'h0040, 0);
        #1 wipe_pin = 1'b1;
        repeat (80) @(posedge ref_clk);
        #1 wipe_pin = 1'b0;
        repeat (6) @(posedge ref_clk);
        req(FPBM_CMD_FULL_ERASE, 16'h0000, 0);
        repeat (8) @(posedge ref_clk);
        chk1("debug_wiped", 1'b1, debug_grant);
        req(FPBM_CMD_PAGE_PROG, 16'h0046, 0);
        chk1("wiped_lock", 1'b0, sw_rsp.locked_err);
        do_rst();
        chk1("boot_rom", 1'b0, boot_map.boot_from_flash);
        chk1("bank_kept", 1'b1, boot_map.boot_bank1);
        final_report();
    end
endmodule : test_flash_protect_boot_map
`default_nettype wire
